// [logic/sts_pkg.sv]
// Package of the sealing temperature supervisor: register map, fields,
// reset values, error codes and timing constants.
// Assumes a 25 MHz core clock and a 32-bit Avalon-MM register bus.
package sts_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TENTH_S_MS = 100;
  localparam int unsigned TENTH_S_CYC = CLK_HZ / 1000 * TENTH_S_MS / 1000;
  localparam int unsigned GAP_MS = 2000;
  localparam int unsigned GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int unsigned COMP_MS = 2000;
  localparam int unsigned COMP_CYC = CLK_HZ / 1000 * COMP_MS;
  localparam int unsigned HOLD2_MS = 2000;
  localparam int unsigned HOLD2_CYC = CLK_HZ / 1000 * HOLD2_MS;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAND = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_TEMP = 8'h18;

  // ==========================================================
  // Control fields and reset values
  // ==========================================================
  localparam int CTRL_COMP_LSB = 0;
  localparam int CTRL_HOLD_LSB = 2;
  localparam int CTRL_DIAG_BIT = 4;
  localparam int CTRL_ERRW_BIT = 5;
  localparam logic [7:0] BAND_LOW_RST = 8'h0a;
  localparam logic [7:0] BAND_HIGH_RST = 8'h0a;
  localparam logic [6:0] DELAY_RST = 7'h00;
  localparam logic [9:0] HEATUP_RST = 10'h000;

  // ==========================================================
  // Modes and error codes
  // ==========================================================
  typedef enum logic [1:0] {COMP_OFF, COMP_ON, COMP_AUTO} sts_comp_type;
  typedef enum logic [1:0] {HOLD_OFF, HOLD_ON, HOLD_2S} sts_hold_type;
  localparam logic [9:0] ERR_HEATUP = 10'h130;
  localparam logic [9:0] ERR_LOW = 10'h133;
  localparam logic [9:0] ERR_HIGH = 10'h134;
  localparam logic [9:0] ERR_NARM_LOW = 10'h135;
  localparam logic [9:0] ERR_NARM_HIGH = 10'h136;
  localparam logic [3:0] SHORT_TEMP = 4'h6;
  localparam logic [3:0] SHORT_HEAT = 4'h7;

  // Interrupt bits.
  localparam int IRQ_DIAG = 0;
  localparam int IRQ_NARM = 1;
  localparam int IRQ_HEAT = 2;
  localparam int IRQ_COMP = 3;

endpackage : sts_pkg

// [logic/sts_supervisor.sv]
// Supervision logic of an impulse heat-sealing temperature controller.
// Assumes the measured temperature, setpoint and the heat-start and
// zeroing handshakes arrive synchronous to core_clk.
`timescale 1ns/1ps

module sts_supervisor #(
  parameter int TEMP_W = 10,
  parameter int GAP_CYCLES = sts_pkg::GAP_CYC,
  parameter int COMP_CYCLES = sts_pkg::COMP_CYC,
  parameter int HOLD2_CYCLES = sts_pkg::HOLD2_CYC,
  parameter int TENTH_CYCLES = sts_pkg::TENTH_S_CYC,
  parameter int BLINK_CYCLES = sts_pkg::BLINK_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [TEMP_W-1:0] actual_temp,
  input wire logic [TEMP_W-1:0] setpoint_temp,
  input wire logic heat_start_bit,
  input wire logic zero_req,
  input wire logic zero_done,
  input wire logic zero_ok,
  output logic zero_with_comp,
  output logic comp_active,
  output logic indicator_led,
  output logic [TEMP_W-1:0] analog_temp,
  output logic [TEMP_W-1:0] bus_temp,
  output logic [9:0] error_number,
  output logic alarm,
  output logic temp_window_ok_flag,
  output logic irq
);

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [1:0] comp_mode_reg;
  logic [1:0] hold_mode_reg;
  logic diag_en_reg;
  logic errw_reg;
  logic [7:0] band_low_reg;
  logic [7:0] band_high_reg;
  logic [6:0] delay_reg;
  logic [9:0] heatup_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_set;
  logic rd_done_reg;
  logic [31:0] rd_next;

  wire wr = avs_write;
  // Reads take one wait cycle so read data come from a flip-flop.
  assign avs_waitrequest = avs_read & ~rd_done_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_done_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done_reg <= avs_read & ~rd_done_reg;
      if (avs_read & ~rd_done_reg) begin
        avs_readdata <= rd_next;
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address)
      sts_pkg::OFS_CTRL: begin
        rd_next = {26'h0, errw_reg, diag_en_reg, hold_mode_reg, comp_mode_reg};
      end
      sts_pkg::OFS_BAND: rd_next = {16'h0, band_high_reg, band_low_reg};
      sts_pkg::OFS_TIME: rd_next = {9'h0, delay_reg, 6'h0, heatup_reg};
      sts_pkg::OFS_STAT: rd_next = {21'h0, alarm, error_number};
      sts_pkg::OFS_IRQ: rd_next = {28'h0, irq_stat_reg};
      sts_pkg::OFS_MASK: rd_next = {28'h0, irq_mask_reg};
      sts_pkg::OFS_TEMP: rd_next = 32'(bus_temp);
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      comp_mode_reg <= 2'(sts_pkg::COMP_OFF);
      hold_mode_reg <= 2'(sts_pkg::HOLD_OFF);
      diag_en_reg <= 1'b0;
      errw_reg <= 1'b0;
      band_low_reg <= sts_pkg::BAND_LOW_RST;
      band_high_reg <= sts_pkg::BAND_HIGH_RST;
      delay_reg <= sts_pkg::DELAY_RST;
      heatup_reg <= sts_pkg::HEATUP_RST;
      irq_mask_reg <= 4'h0;
    end else if (wr && avs_byteenable[0]) begin
      case (avs_address)
        sts_pkg::OFS_CTRL: begin
          comp_mode_reg <= avs_writedata[sts_pkg::CTRL_COMP_LSB +: 2];
          hold_mode_reg <= avs_writedata[sts_pkg::CTRL_HOLD_LSB +: 2];
          diag_en_reg <= avs_writedata[sts_pkg::CTRL_DIAG_BIT];
          errw_reg <= avs_writedata[sts_pkg::CTRL_ERRW_BIT];
        end
        sts_pkg::OFS_BAND: begin
          band_low_reg <= avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            band_high_reg <= avs_writedata[15:8];
          end
        end
        sts_pkg::OFS_TIME: begin
          heatup_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            heatup_reg[9:8] <= avs_writedata[9:8];
          end
          if (avs_byteenable[2]) begin
            delay_reg <= avs_writedata[22:16];
          end
        end
        sts_pkg::OFS_MASK: irq_mask_reg <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // Set wins over a simultaneous write-one-to-clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (irq_set[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr && avs_byteenable[0] &&
                     avs_address == sts_pkg::OFS_IRQ && avs_writedata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // Zeroing sequencer and phase compensation
  // ==========================================================
  typedef enum {ZS_IDLE, ZS_ZERO, ZS_COMP} sts_zs_type;
  sts_zs_type zs_reg;
  logic [31:0] gap_reg;
  logic [31:0] comp_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic fast_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      zs_reg <= ZS_IDLE;
      gap_reg <= 32'hffff_ffff;
      comp_cnt_reg <= 32'h0;
      fast_reg <= 1'b0;
    end else begin
      if (gap_reg != 32'hffff_ffff) begin
        gap_reg <= gap_reg + 32'h1;
      end
      case (zs_reg)
        ZS_IDLE: begin
          if (zero_req) begin
            fast_reg <= comp_mode_reg == 2'(sts_pkg::COMP_ON) &&
                        gap_reg < 32'(GAP_CYCLES);
            zs_reg <= ZS_ZERO;
          end
        end
        ZS_ZERO: begin
          if (fast_reg) begin
            zs_reg <= ZS_COMP;
            comp_cnt_reg <= 32'h0;
          end else if (zero_done) begin
            gap_reg <= 32'h0;
            if (zero_ok && comp_mode_reg == 2'(sts_pkg::COMP_AUTO)) begin
              zs_reg <= ZS_COMP;
              comp_cnt_reg <= 32'h0;
            end else begin
              zs_reg <= ZS_IDLE;
            end
          end
        end
        ZS_COMP: begin
          comp_cnt_reg <= comp_cnt_reg + 32'h1;
          if (comp_cnt_reg == 32'(COMP_CYCLES - 1)) begin
            zs_reg <= ZS_IDLE;
            fast_reg <= 1'b0;
            gap_reg <= 32'hffff_ffff;
          end
        end
        default: zs_reg <= ZS_IDLE;
      endcase
    end
  end

  assign comp_active = zs_reg == ZS_COMP;
  assign zero_with_comp = fast_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (!comp_active) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  assign indicator_led = blink_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      analog_temp <= '0;
    end else begin
      analog_temp <= comp_active ? '0 : actual_temp;
    end
  end

  // ==========================================================
  // Temperature band and diagnosis
  // ==========================================================
  logic [TEMP_W+1:0] lo_lim;
  logic [TEMP_W+1:0] hi_lim;
  logic [TEMP_W+1:0] act_x;
  logic above_lo;
  logic in_band;
  logic start_d_reg;
  logic armed_reg;
  logic [31:0] dly_cnt_reg;
  logic [9:0] err_reg;
  logic alarm_reg;

  assign act_x = (TEMP_W+2)'(actual_temp);
  assign lo_lim = (TEMP_W+2)'(setpoint_temp) - (TEMP_W+2)'(band_low_reg);
  assign hi_lim = (TEMP_W+2)'(setpoint_temp) + (TEMP_W+2)'(band_high_reg);
  assign above_lo = $signed(act_x) >= $signed(lo_lim);
  assign in_band = above_lo && act_x <= hi_lim;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      temp_window_ok_flag <= 1'b0;
    end else begin
      temp_window_ok_flag <= in_band;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_d_reg <= 1'b0;
      armed_reg <= 1'b0;
      dly_cnt_reg <= 32'h0;
    end else begin
      start_d_reg <= heat_start_bit;
      if (!heat_start_bit || !diag_en_reg) begin
        armed_reg <= 1'b0;
        dly_cnt_reg <= 32'h0;
      end else if (!armed_reg && in_band) begin
        if (dly_cnt_reg >= 32'(delay_reg) * 32'(TENTH_CYCLES)) begin
          armed_reg <= 1'b1;
        end else begin
          dly_cnt_reg <= dly_cnt_reg + 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // Heat-up monitoring
  // ==========================================================
  logic [31:0] heat_cnt_reg;
  logic heat_run_reg;
  logic reached95;

  assign reached95 = 32'(actual_temp) * 32'd100 >= 32'(setpoint_temp) * 32'd95;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      heat_cnt_reg <= 32'h0;
      heat_run_reg <= 1'b0;
    end else if (heat_start_bit && !start_d_reg && heatup_reg != 10'h0) begin
      heat_cnt_reg <= 32'h0;
      heat_run_reg <= 1'b1;
    end else if (heat_run_reg) begin
      heat_cnt_reg <= heat_cnt_reg + 32'h1;
      if (reached95 || !heat_start_bit) begin
        heat_run_reg <= 1'b0;
      end
    end
  end

  wire heat_late = heat_run_reg && !reached95 &&
                   heat_cnt_reg == 32'(heatup_reg) * 32'(TENTH_CYCLES);
  wire diag_leave = armed_reg && heat_start_bit && !in_band;
  wire narm = diag_en_reg && start_d_reg && !heat_start_bit && !armed_reg;

  // Errors latch with the alarm until the next heat start, but a heat-up error overwrites a latched one.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_reg <= 10'h0;
      alarm_reg <= 1'b0;
    end else if (heat_late) begin
      err_reg <= sts_pkg::ERR_HEATUP;
      alarm_reg <= 1'b1;
    end else if (diag_leave && !alarm_reg) begin
      err_reg <= above_lo ? sts_pkg::ERR_HIGH : sts_pkg::ERR_LOW;
      alarm_reg <= 1'b1;
    end else if (narm && !alarm_reg) begin
      err_reg <= above_lo ? sts_pkg::ERR_NARM_HIGH : sts_pkg::ERR_NARM_LOW;
      alarm_reg <= 1'b1;
    end else if (heat_start_bit && !start_d_reg) begin
      err_reg <= 10'h0;
      alarm_reg <= 1'b0;
    end
  end

  assign alarm = alarm_reg;
  assign error_number = errw_reg ? err_reg :
      (err_reg == 10'h0 ? 10'h0 :
       {6'h0, err_reg == sts_pkg::ERR_HEATUP ? sts_pkg::SHORT_HEAT :
                                               sts_pkg::SHORT_TEMP});
  assign irq_set = {comp_active & (zs_reg != ZS_COMP ? 1'b0 : comp_cnt_reg == 0),
                    heat_late, narm, diag_leave & ~alarm_reg};

  // ==========================================================
  // Hold of the fieldbus temperature
  // ==========================================================
  logic [TEMP_W-1:0] held_reg;
  logic have_held_reg;
  logic [31:0] hold_cnt_reg;
  wire seal_end = start_d_reg && !heat_start_bit;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      held_reg <= '0;
      have_held_reg <= 1'b0;
      hold_cnt_reg <= 32'h0;
    end else if (seal_end) begin
      held_reg <= actual_temp;
      have_held_reg <= 1'b1;
      hold_cnt_reg <= 32'(HOLD2_CYCLES);
    end else if (hold_cnt_reg != 32'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_temp <= '0;
    end else if (hold_mode_reg == 2'(sts_pkg::HOLD_ON) && have_held_reg) begin
      bus_temp <= seal_end ? actual_temp : held_reg;
    end else if (hold_mode_reg == 2'(sts_pkg::HOLD_2S) &&
                 (seal_end || hold_cnt_reg != 32'h0)) begin
      bus_temp <= seal_end ? actual_temp : held_reg;
    end else begin
      bus_temp <= actual_temp;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_comp_reset: assert property (@(posedge core_clk) srst |=>
    comp_mode_reg == 2'(sts_pkg::COMP_OFF)) else $error("comp not off");
  a_fast_comp: assert property (@(posedge core_clk) disable iff (srst)
    zs_reg == ZS_ZERO && fast_reg |=> comp_active) else $error("no comp");
  sequence s_fast_req;
    zs_reg == ZS_IDLE && zero_req && gap_reg < 32'(GAP_CYCLES) &&
    comp_mode_reg == 2'(sts_pkg::COMP_ON);
  endsequence
  sequence s_fast_run;
    zero_with_comp ##1 comp_active;
  endsequence
  a_fast_repeat: assert property (@(posedge core_clk) disable iff (srst)
    s_fast_req |=> s_fast_run) else $error("fast repeat not compensated");
  a_slow_plain: assert property (@(posedge core_clk) disable iff (srst)
    zs_reg == ZS_IDLE && zero_req && gap_reg >= 32'(GAP_CYCLES) |=> !fast_reg)
    else $error("slow run compensated");
  a_analog_zero: assert property (@(posedge core_clk) disable iff (srst)
    comp_active |=> analog_temp == '0) else $error("analogue not zero");
  a_auto_comp: assert property (@(posedge core_clk) disable iff (srst)
    zs_reg == ZS_ZERO && !fast_reg && zero_done && zero_ok &&
    comp_mode_reg == 2'(sts_pkg::COMP_AUTO) |=> comp_active)
    else $error("auto comp missing");
  a_leave_alarm: assert property (@(posedge core_clk) disable iff (srst)
    diag_leave |=> alarm) else $error("no alarm on leave");
  a_narm_alarm: assert property (@(posedge core_clk) disable iff (srst)
    narm && !heat_late |=> alarm) else $error("no alarm unarmed");
  a_live_off: assert property (@(posedge core_clk) disable iff (srst)
    hold_mode_reg == 2'(sts_pkg::HOLD_OFF) |=> bus_temp == $past(actual_temp))
    else $error("hold off not live");
  a_analog_live: assert property (@(posedge core_clk) disable iff (srst)
    !comp_active |=> analog_temp == $past(actual_temp))
    else $error("analogue not live");

endmodule : sts_supervisor

// [sim/sts_zero_model.sv]
// Behavioural model of the external zeroing engine.
// Assumes zero_req is a one-cycle pulse synchronous to core_clk.
`timescale 1ns/1ps
module sts_zero_model #(
  parameter int DUR = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic zero_req,
  input wire logic zero_with_comp,
  input wire logic ok_cfg,
  output logic zero_done,
  output logic zero_ok
);
  // A fast repeat is run by the device alone, so no end pulse is given.
  initial begin
    zero_done = 1'b0;
    forever begin
      @(posedge core_clk);
      if (zero_req === 1'b1 && srst === 1'b0) begin
        repeat (2) @(posedge core_clk);
        if (zero_with_comp !== 1'b1) begin
          repeat (DUR) @(posedge core_clk);
          zero_done <= 1'b1;
          @(posedge core_clk);
          zero_done <= 1'b0;
        end
      end
    end
  end
  // The outcome line carries no meaning outside the end pulse.
  assign zero_ok = zero_done ? ok_cfg : ~ok_cfg;
endmodule : sts_zero_model

// [sim/test_sts_supervisor.sv]
// Self-checking bench of the sealing temperature supervisor.
// Assumes the zeroing engine model and shortened timing counts.
`timescale 1ns/1ps
module test_sts_supervisor;
  localparam int GAP = 40;
  localparam int COMP = 20;
  localparam int HOLD2 = 30;
  localparam int TENTH = 10;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] actual_temp = 10'h000;
  logic [9:0] setpoint_temp = 10'h064;
  logic heat_start_bit = 1'b0;
  logic zero_req = 1'b0;
  logic ok_cfg = 1'b1;
  logic zero_done, zero_ok, zero_with_comp, comp_active, indicator_led;
  logic [9:0] analog_temp, bus_temp, error_number;
  logic alarm, temp_window_ok_flag, irq;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] d;

  always #20 core_clk = ~core_clk;

  sts_supervisor #(.GAP_CYCLES(GAP), .COMP_CYCLES(COMP),
    .HOLD2_CYCLES(HOLD2), .TENTH_CYCLES(TENTH), .BLINK_CYCLES(4)) uut (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .actual_temp(actual_temp), .setpoint_temp(setpoint_temp),
    .heat_start_bit(heat_start_bit), .zero_req(zero_req),
    .zero_done(zero_done), .zero_ok(zero_ok),
    .zero_with_comp(zero_with_comp), .comp_active(comp_active),
    .indicator_led(indicator_led), .analog_temp(analog_temp),
    .bus_temp(bus_temp), .error_number(error_number), .alarm(alarm),
    .temp_window_ok_flag(temp_window_ok_flag), .irq(irq));

  sts_zero_model zm (.core_clk(core_clk), .srst(srst), .zero_req(zero_req),
    .zero_with_comp(zero_with_comp), .ok_cfg(ok_cfg),
    .zero_done(zero_done), .zero_ok(zero_ok));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : rd

  task automatic seal(input logic [9:0] v);
    actual_temp <= v;
    heat_start_bit <= 1'b1;
    cyc(4);
    heat_start_bit <= 1'b0;
    cyc(2);
  endtask : seal

  // Requests one zeroing run and watches a fixed window for compensation.
  task automatic zrun(input int e, input logic w);
    int n;
    int t;
    int bad;
    logic led;
    logic pc;
    logic wc;
    wc = 1'b0;
    n = 0;
    t = 0;
    bad = 0;
    led = 1'b0;
    pc = 1'b0;
    zero_req <= 1'b1;
    @(posedge core_clk);
    zero_req <= 1'b0;
    repeat (40) begin
      @(posedge core_clk);
      if (comp_active === 1'b1) n++;
      if (zero_with_comp === 1'b1) wc = 1'b1;
      if (comp_active === 1'b1 && pc && analog_temp !== 10'h000) bad++;
      if (indicator_led !== led) t++;
      led = indicator_led;
      pc = comp_active;
    end
    chk("comp cycles", n, e);
    chk("with comp", {31'h0, wc}, {31'h0, w});
    chk("analog zero", bad, 0);
    chk("blinking", {31'h0, t >= 2}, {31'h0, e > 0});
  endtask : zrun

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    rd(sts_pkg::OFS_CTRL);
    chk("ctrl", d, 32'h0);
    rd(sts_pkg::OFS_BAND);
    chk("band", d, 32'h0a0a);
    rd(sts_pkg::OFS_TIME);
    chk("time", d, 32'h0);
    rd(8'h40);
    chk("unmapped", d, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_hold();
    actual_temp <= 10'h037;
    cyc(3);
    chk("live", bus_temp, 10'h037);
    wr(sts_pkg::OFS_CTRL, 32'h4);
    actual_temp <= 10'h03c;
    cyc(3);
    chk("first", bus_temp, 10'h03c);
    seal(10'h046);
    actual_temp <= 10'h050;
    cyc(3);
    chk("held", bus_temp, 10'h046);
    chk("analog", analog_temp, 10'h050);
    rd(sts_pkg::OFS_TEMP);
    chk("held reg", d, 32'h46);
    wr(sts_pkg::OFS_CTRL, 32'h8);
    seal(10'h05a);
    actual_temp <= 10'h05f;
    cyc(3);
    chk("timed", bus_temp, 10'h05a);
    cyc(HOLD2 - 8);
    chk("still held", bus_temp, 10'h05a);
    cyc(8);
    chk("released", bus_temp, 10'h05f);
    wr(sts_pkg::OFS_CTRL, 32'h0);
    $display("hold test done");
  endtask : t_hold

  task automatic t_band();
    logic [9:0] a [8] = '{10'h059, 10'h05a, 10'h06e, 10'h06f,
                          10'h061, 10'h062, 10'h067, 10'h068};
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(sts_pkg::OFS_BAND, 32'h0302);
      actual_temp <= a[i];
      cyc(3);
      chk("window", temp_window_ok_flag, i % 4 == 1 || i % 4 == 2);
    end
    wr(sts_pkg::OFS_BAND, 32'h0a0a);
    $display("band test done");
  endtask : t_band

  task automatic t_diag();
    wr(sts_pkg::OFS_TIME, 32'h00020000);
    wr(sts_pkg::OFS_CTRL, 32'h30);
    actual_temp <= 10'h032;
    heat_start_bit <= 1'b1;
    cyc(3);
    actual_temp <= 10'h064;
    cyc(2 * TENTH - 5);
    actual_temp <= 10'h055;
    cyc(3);
    chk("early arm", alarm, 1'b0);
    heat_start_bit <= 1'b0;
    cyc(3);
    chk("not armed", error_number, sts_pkg::ERR_NARM_LOW);
    chk("alarm", alarm, 1'b1);
    heat_start_bit <= 1'b1;
    actual_temp <= 10'h064;
    cyc(2 * TENTH + 5);
    actual_temp <= 10'h073;
    cyc(3);
    chk("left band", error_number, sts_pkg::ERR_HIGH);
    rd(sts_pkg::OFS_STAT);
    chk("status", d, 32'h534);
    heat_start_bit <= 1'b0;
    wr(sts_pkg::OFS_CTRL, 32'h10);
    actual_temp <= 10'h082;
    heat_start_bit <= 1'b1;
    cyc(5);
    heat_start_bit <= 1'b0;
    cyc(3);
    chk("short", error_number, {6'h00, sts_pkg::SHORT_TEMP});
    $display("diag test done");
  endtask : t_diag

  task automatic t_heat();
    wr(sts_pkg::OFS_CTRL, 32'h20);
    wr(sts_pkg::OFS_TIME, 32'h1);
    actual_temp <= 10'h05f;
    heat_start_bit <= 1'b1;
    cyc(3 * TENTH);
    chk("in time", alarm, 1'b0);
    heat_start_bit <= 1'b0;
    actual_temp <= 10'h032;
    cyc(2);
    heat_start_bit <= 1'b1;
    cyc(TENTH / 2);
    chk("early", alarm, 1'b0);
    cyc(TENTH + 5);
    chk("late", error_number, sts_pkg::ERR_HEATUP);
    chk("late alarm", alarm, 1'b1);
    chk("masked irq", irq, 1'b0);
    wr(sts_pkg::OFS_MASK, 32'h4);
    cyc(2);
    chk("irq", irq, 1'b1);
    wr(sts_pkg::OFS_IRQ, 32'h4);
    cyc(2);
    chk("cleared irq", irq, 1'b0);
    heat_start_bit <= 1'b0;
    $display("heat test done");
  endtask : t_heat

  task automatic t_comp();
    wr(sts_pkg::OFS_CTRL, 32'h0);
    actual_temp <= 10'h037;
    zrun(0, 1'b0);
    zrun(0, 1'b0);
    wr(sts_pkg::OFS_CTRL, 32'h1);
    cyc(GAP);
    zrun(0, 1'b0);
    zrun(COMP, 1'b1);
    zrun(0, 1'b0);
    cyc(GAP);
    zrun(0, 1'b0);
    wr(sts_pkg::OFS_CTRL, 32'h2);
    ok_cfg <= 1'b0;
    zrun(0, 1'b0);
    ok_cfg <= 1'b1;
    zrun(COMP, 1'b0);
    rd(sts_pkg::OFS_IRQ);
    chk("irq status", d, 32'hb);
    $display("compensation test done");
  endtask : t_comp

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    t_reset();
    t_hold();
    t_band();
    t_diag();
    t_heat();
    t_comp();
    final_report();
  end

  initial begin
    cyc(30000);
    n_mismatch++;
    final_report();
  end
endmodule : test_sts_supervisor
